// File: tb/pss_mgr_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Station manager issuing reads
module pss_mgr_model (
  // Clock
  input  wire logic               clk_sys_i,
  // Answer
  input  wire logic               rd_valid_i,
  input  wire pss_pkg::pss_word_t rd_data_i,
  // Request
  output var logic                mgmt_rd_o,
  output var pss_pkg::pss_addr_t  mgmt_addr_o
);
  initial begin
    mgmt_rd_o = 1'b0;
    mgmt_addr_o = 5'h00;
  end
  // Idle address inverted so no stale value lingers
  task automatic read(input pss_pkg::pss_addr_t a, output logic ok,
                      output pss_pkg::pss_word_t d);
    @(posedge clk_sys_i);
    #1 mgmt_rd_o = 1'b1;
    mgmt_addr_o = a;
    @(posedge clk_sys_i);
    #1 mgmt_rd_o = 1'b0;
    mgmt_addr_o = ~a;
    ok = rd_valid_i;
    d = rd_data_i;
  endtask
endmodule
`default_nettype wire

// File: tb/pss_status_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checks
module pss_status_chk (
  // Clock and reset
  input wire logic               clk_sys_i,
  input wire logic               resetn_i,
  // Read port
  input wire logic               mgmt_rd_i,
  input wire pss_pkg::pss_addr_t mgmt_addr_i,
  // Sources
  input wire logic               rx_error_event_i,
  input wire logic               interrupt_event_i,
  input wire logic               jabber_detect_i,
  input wire logic               auto_crossover_enable_i,
  input wire logic               forced_crossover_i,
  input wire logic               crossover_swapped_i,
  // Answer
  input wire logic               rd_valid_o,
  input wire pss_pkg::pss_word_t rd_data_o,
  input wire pss_pkg::pss_word_t status_summary_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire logic sum_rd = mgmt_rd_i && mgmt_addr_i == 5'h10;
  wire logic xo_exp = forced_crossover_i || (auto_crossover_enable_i && crossover_swapped_i);
  rd_answer_a: assert property (sum_rd |=> rd_valid_o)
    else $error("summary read not answered");
  no_stray_a: assert property (!sum_rd |=> !rd_valid_o)
    else $error("answer without summary read");
  rd_word_a: assert property (rd_valid_o |-> rd_data_o == status_summary_o)
    else $error("read word differs from live word");
  reserved_zero_a: assert property (!status_summary_o[15] && !rd_data_o[15])
    else $error("reserved bit set");
  xo_set_a: assert property (xo_exp |-> ##2 status_summary_o[14])
    else $error("crossover bit not set");
  xo_clear_a: assert property (!xo_exp |-> ##2 !status_summary_o[14])
    else $error("crossover bit not clear");
  jabber_mirror_a: assert property (##2 status_summary_o[5] == $past(jabber_detect_i, 2))
    else $error("jabber bit not mirrored");
  rx_err_set_a: assert property (rx_error_event_i |-> ##2 status_summary_o[13])
    else $error("receive error not latched");
  rx_err_clear_a: assert property (mgmt_rd_i && mgmt_addr_i == 5'h15 && !rx_error_event_i
    |-> ##2 !status_summary_o[13]) else $error("receive error not cleared");
  int_set_a: assert property (interrupt_event_i |-> ##2 status_summary_o[7])
    else $error("interrupt bit not set");
  page_keep_a: assert property (
    !(mgmt_rd_i && mgmt_addr_i == 5'h06) ##1 status_summary_o[8] |=> status_summary_o[8])
    else $error("page bit lost");
  cover property (sum_rd ##1 rd_data_o[13]);
  cover property (rx_error_event_i && mgmt_rd_i && mgmt_addr_i == 5'h15);
  cover property (rd_valid_o && rd_data_o[10]);
  cover property (status_summary_o[14]);
endmodule
bind pss_status_upper pss_status_chk chk (
  .clk_sys_i               (clk_sys_i),
  .resetn_i                (resetn_i),
  .mgmt_rd_i               (mgmt_rd_i),
  .mgmt_addr_i             (mgmt_addr_i),
  .rx_error_event_i        (rx_error_event_i),
  .interrupt_event_i       (interrupt_event_i),
  .jabber_detect_i         (jabber_detect_i),
  .auto_crossover_enable_i (auto_crossover_enable_i),
  .forced_crossover_i      (forced_crossover_i),
  .crossover_swapped_i     (crossover_swapped_i),
  .rd_valid_o              (rd_valid_o),
  .rd_data_o               (rd_data_o),
  .status_summary_o        (status_summary_o)
);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========
  // Wiring and bench model
  logic               clk_sys_i = 1'b0;
  logic               resetn_i = 1'b0;
  logic [5:0]         ev = 6'h00;
  logic               jabber_detect_i = 1'b0;
  logic               signal_detect_i = 1'b0;
  logic               descrambler_lock_i = 1'b0;
  logic               auto_crossover_enable_i = 1'b0;
  logic               forced_crossover_i = 1'b0;
  logic               crossover_swapped_i = 1'b0;
  logic               mgmt_rd_i;
  pss_pkg::pss_addr_t mgmt_addr_i;
  pss_pkg::pss_word_t rd_data_o;
  pss_pkg::pss_word_t status_summary_o;
  logic               rd_valid_o;
  wire logic          rx_error_event_i = ev[0];
  wire logic          false_carrier_event_i = ev[1];
  wire logic          polarity_inverted_event_i = ev[2];
  wire logic          page_received_event_i = ev[3];
  wire logic          interrupt_event_i = ev[4];
  wire logic          remote_fault_event_i = ev[5];
  logic [5:0]         fl = 6'h00;
  logic [1:0]         ll = 2'b00;
  logic               ok;
  pss_pkg::pss_word_t d;
  int                 k;
  int                 num_errors = 0;
  int                 total_checks = 0;
  int                 pos[6] = '{13, 11, 12, 8, 7, 6};
  pss_pkg::pss_addr_t clr[6] = '{5'h15, 5'h14, 5'h1a, 5'h06, 5'h12, 5'h01};

  always #5 clk_sys_i = ~clk_sys_i;

  pss_status_upper uut (
    .clk_sys_i                 (clk_sys_i),
    .resetn_i                  (resetn_i),
    .mgmt_rd_i                 (mgmt_rd_i),
    .mgmt_addr_i               (mgmt_addr_i),
    .rx_error_event_i          (rx_error_event_i),
    .false_carrier_event_i     (false_carrier_event_i),
    .polarity_inverted_event_i (polarity_inverted_event_i),
    .page_received_event_i     (page_received_event_i),
    .interrupt_event_i         (interrupt_event_i),
    .remote_fault_event_i      (remote_fault_event_i),
    .jabber_detect_i           (jabber_detect_i),
    .signal_detect_i           (signal_detect_i),
    .descrambler_lock_i        (descrambler_lock_i),
    .auto_crossover_enable_i   (auto_crossover_enable_i),
    .forced_crossover_i        (forced_crossover_i),
    .crossover_swapped_i       (crossover_swapped_i),
    .rd_data_o                 (rd_data_o),
    .rd_valid_o                (rd_valid_o),
    .status_summary_o          (status_summary_o)
  );
  pss_mgr_model mgr (.clk_sys_i(clk_sys_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
                     .mgmt_rd_o(mgmt_rd_i), .mgmt_addr_o(mgmt_addr_i));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Summary read against the bench model, then rearm latch-low copy
  task automatic sum_chk();
    pss_pkg::pss_word_t w;
    w = 16'h0000;
    for (int j = 0; j < 6; j++) w[pos[j]] = fl[j];
    w[14] = forced_crossover_i | (auto_crossover_enable_i & crossover_swapped_i);
    w[10:9] = ll;
    w[5] = jabber_detect_i;
    mgr.read(5'h10, ok, d);
    check({15'h0000, ok}, 16'h0001);
    check(d, w);
    check(status_summary_o, w);
    ll = {signal_detect_i, descrambler_lock_i};
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========
  // Tests
  initial begin
    void'($urandom(95745));
    repeat (4) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    sum_chk();
    mgr.read(5'h1f, ok, d);
    check({15'h0000, ok}, 16'h0000);
    $display("reset test done");
    signal_detect_i = 1'b1;
    descrambler_lock_i = 1'b1;
    repeat (2) sum_chk();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      #1 {signal_detect_i, descrambler_lock_i} = ~(2'b01 << i);
      ll = ll & ~(2'b01 << i);
      @(posedge clk_sys_i);
      #1 {signal_detect_i, descrambler_lock_i} = 2'b11;
      repeat (2) sum_chk();
    end
    $display("latch low test done");
    for (int n = 0; n < 60; n++) begin
      @(posedge clk_sys_i);
      #1 {jabber_detect_i, auto_crossover_enable_i, forced_crossover_i,
          crossover_swapped_i} = 4'($urandom);
      k = $urandom_range(5, 0);
      if ($urandom_range(1, 0) == 1) begin
        ev[k] = 1'b1;
        fl[k] = 1'b1;
        @(posedge clk_sys_i);
        #1 ev = 6'h00;
      end else begin
        mgr.read(clr[k], ok, d);
        check({15'h0000, ok}, 16'h0000);
        fl[k] = 1'b0;
      end
      sum_chk();
    end
    $display("random test done");
    fork
      mgr.read(5'h15, ok, d);
      begin
        @(posedge clk_sys_i);
        #1 ev[0] = 1'b1;
        @(posedge clk_sys_i);
        #1 ev = 6'h00;
      end
    join
    fl[0] = 1'b1;
    check({15'h0000, ok}, 16'h0000);
    sum_chk();
    $display("set over clear test done");
    @(posedge clk_sys_i);
    #1 ev = 6'h3f;
    @(posedge clk_sys_i);
    #1 ev = 6'h00;
    resetn_i = 1'b0;
    {jabber_detect_i, auto_crossover_enable_i, forced_crossover_i, crossover_swapped_i} = 4'h0;
    fl = 6'h00;
    ll = 2'b00;
    @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    check(status_summary_o, 16'h0000);
    sum_chk();
    $display("mid-run reset test done");
    complete_run();
  end

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire

// File: verilog/pss_flag_latch.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Sticky flag: set wins over clear
module pss_flag_latch (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // Control
  input  wire logic set_i,
  input  wire logic clear_i,
  // Flag
  output logic      flag_o
);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: verilog/pss_params.svh
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ============================================================
// Management register addresses
`define PSS_ADDR_BASIC_STATUS     5'h01
`define PSS_ADDR_AUTONEG_EXP      5'h06
`define PSS_ADDR_STATUS_SUMMARY   5'h10
`define PSS_ADDR_INTERRUPT_SOURCE 5'h12
`define PSS_ADDR_FALSE_CARRIER    5'h14
`define PSS_ADDR_RX_ERROR         5'h15
`define PSS_ADDR_TENBASE_T_STATUS 5'h1a

// ============================================================
// Field positions in the status summary word
`define PSS_BIT_RESERVED          15
`define PSS_BIT_CROSSOVER         14
`define PSS_BIT_RX_ERROR          13
`define PSS_BIT_POLARITY          12
`define PSS_BIT_FALSE_CARRIER     11
`define PSS_BIT_SIGNAL_DETECT     10
`define PSS_BIT_DESCRAMBLER_LOCK  9
`define PSS_BIT_PAGE_RECEIVED     8
`define PSS_BIT_INTERRUPT         7
`define PSS_BIT_REMOTE_FAULT      6
`define PSS_BIT_JABBER            5

// ============================================================
// Reset values
`define PSS_RESET_SUMMARY         16'h0000

`endif

// File: verilog/pss_pkg.sv
// ============================================================
// Types
package pss_pkg;

  typedef logic [4:0]  pss_addr_t;
  typedef logic [15:0] pss_word_t;

  typedef enum logic [2:0] {
    PSS_XO_NORMAL = 3'b001,
    PSS_XO_AUTO   = 3'b010,
    PSS_XO_FORCED = 3'b100
  } pss_xo_mode_t;

endpackage

// File: verilog/pss_status_upper.sv
`include "pss_params.svh"
`timescale 1ns/1ns
`default_nettype none

module pss_status_upper (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             resetn_i,
  // Management read port
  input  wire logic             mgmt_rd_i,
  input  wire pss_pkg::pss_addr_t mgmt_addr_i,
  // Event sources, one-cycle pulses
  input  wire logic             rx_error_event_i,
  input  wire logic             false_carrier_event_i,
  input  wire logic             polarity_inverted_event_i,
  input  wire logic             page_received_event_i,
  input  wire logic             interrupt_event_i,
  input  wire logic             remote_fault_event_i,
  // Level sources
  input  wire logic             jabber_detect_i,
  input  wire logic             signal_detect_i,
  input  wire logic             descrambler_lock_i,
  // Crossover control and state
  input  wire logic             auto_crossover_enable_i,
  input  wire logic             forced_crossover_i,
  input  wire logic             crossover_swapped_i,
  // Read answer
  output pss_pkg::pss_word_t    rd_data_o,
  output logic                  rd_valid_o,
  // Live view of the summary word
  output pss_pkg::pss_word_t    status_summary_o
);

  // ============================================================
  // Address decode
  function automatic logic read_of(input logic rd, input pss_pkg::pss_addr_t addr,
                                   input pss_pkg::pss_addr_t target);
    read_of = rd && (addr == target);
  endfunction

  function automatic logic latch_low(input logic q, input logic src, input logic rearm);
    latch_low = rearm ? src : (q & src);
  endfunction

  logic rd_summary;
  logic rd_basic_status;
  logic rd_autoneg_exp;
  logic rd_interrupt_source;
  logic rd_false_carrier;
  logic rd_rx_error;
  logic rd_tenbase_t;

  assign rd_summary          = read_of(mgmt_rd_i, mgmt_addr_i, `PSS_ADDR_STATUS_SUMMARY);
  assign rd_basic_status     = read_of(mgmt_rd_i, mgmt_addr_i, `PSS_ADDR_BASIC_STATUS);
  assign rd_autoneg_exp      = read_of(mgmt_rd_i, mgmt_addr_i, `PSS_ADDR_AUTONEG_EXP);
  assign rd_interrupt_source = read_of(mgmt_rd_i, mgmt_addr_i, `PSS_ADDR_INTERRUPT_SOURCE);
  assign rd_false_carrier    = read_of(mgmt_rd_i, mgmt_addr_i, `PSS_ADDR_FALSE_CARRIER);
  assign rd_rx_error         = read_of(mgmt_rd_i, mgmt_addr_i, `PSS_ADDR_RX_ERROR);
  assign rd_tenbase_t        = read_of(mgmt_rd_i, mgmt_addr_i, `PSS_ADDR_TENBASE_T_STATUS);

  // ============================================================
  // Sticky flags cleared by reads of their owning registers
  logic rx_error_flag;
  logic false_carrier_flag;
  logic polarity_flag;
  logic page_received_flag;
  logic interrupt_flag;
  logic remote_fault_flag;

  // Counter read clears receive error latch
  pss_flag_latch u_rx_error (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (rx_error_event_i),
    .clear_i   (rd_rx_error),
    .flag_o    (rx_error_flag)
  );

  // Counter read clears false carrier latch
  pss_flag_latch u_false_carrier (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (false_carrier_event_i),
    .clear_i   (rd_false_carrier),
    .flag_o    (false_carrier_flag)
  );

  // Polarity copy, summary read leaves it alone
  pss_flag_latch u_polarity (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (polarity_inverted_event_i),
    .clear_i   (rd_tenbase_t),
    .flag_o    (polarity_flag)
  );

  // Page received copy, cleared by expansion read
  pss_flag_latch u_page_received (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (page_received_event_i),
    .clear_i   (rd_autoneg_exp),
    .flag_o    (page_received_flag)
  );

  // Interrupt pending, cleared by source register read
  pss_flag_latch u_interrupt (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (interrupt_event_i),
    .clear_i   (rd_interrupt_source),
    .flag_o    (interrupt_flag)
  );

  // Remote fault, cleared by basic status read or reset
  pss_flag_latch u_remote_fault (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (remote_fault_event_i),
    .clear_i   (rd_basic_status),
    .flag_o    (remote_fault_flag)
  );

  // ============================================================
  // Jabber mirror
  logic jabber_flag;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jabber_flag <= 1'b0;
    end else begin
      jabber_flag <= jabber_detect_i;
    end
  end

  // ============================================================
  // Latch-low medium indications
  logic signal_detect_ll;
  logic descrambler_lock_ll;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      signal_detect_ll <= 1'b0;
    end else begin
      signal_detect_ll <= latch_low(signal_detect_ll, signal_detect_i, rd_summary);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      descrambler_lock_ll <= 1'b0;
    end else begin
      descrambler_lock_ll <= latch_low(descrambler_lock_ll, descrambler_lock_i,
                                       rd_summary);
    end
  end

  // ============================================================
  // Crossover state
  pss_pkg::pss_xo_mode_t xo_mode;
  logic                  crossover_flag;
  logic                  next_crossover_flag;

  always_comb begin
    if (forced_crossover_i) begin
      xo_mode = pss_pkg::PSS_XO_FORCED;
    end else if (auto_crossover_enable_i) begin
      xo_mode = pss_pkg::PSS_XO_AUTO;
    end else begin
      xo_mode = pss_pkg::PSS_XO_NORMAL;
    end
  end

  always_comb begin
    case (xo_mode)
      pss_pkg::PSS_XO_FORCED: begin
        next_crossover_flag = 1'b1;
      end
      pss_pkg::PSS_XO_AUTO: begin
        next_crossover_flag = crossover_swapped_i;
      end
      pss_pkg::PSS_XO_NORMAL: begin
        next_crossover_flag = 1'b0;
      end
      default: begin
        next_crossover_flag = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crossover_flag <= 1'b0;
    end else begin
      crossover_flag <= next_crossover_flag;
    end
  end

  // ============================================================
  // Summary word assembly
  pss_pkg::pss_word_t summary_word;

  always_comb begin
    summary_word                            = `PSS_RESET_SUMMARY;
    summary_word[`PSS_BIT_RESERVED]         = 1'b0;
    summary_word[`PSS_BIT_CROSSOVER]        = crossover_flag;
    summary_word[`PSS_BIT_RX_ERROR]         = rx_error_flag;
    summary_word[`PSS_BIT_POLARITY]         = polarity_flag;
    summary_word[`PSS_BIT_FALSE_CARRIER]    = false_carrier_flag;
    summary_word[`PSS_BIT_SIGNAL_DETECT]    = signal_detect_ll;
    summary_word[`PSS_BIT_DESCRAMBLER_LOCK] = descrambler_lock_ll;
    summary_word[`PSS_BIT_PAGE_RECEIVED]    = page_received_flag;
    summary_word[`PSS_BIT_INTERRUPT]        = interrupt_flag;
    summary_word[`PSS_BIT_REMOTE_FAULT]     = remote_fault_flag;
    summary_word[`PSS_BIT_JABBER]           = jabber_flag;
  end

  // ============================================================
  // Read answer, value taken before any read side effect
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= `PSS_RESET_SUMMARY;
    end else if (rd_summary) begin
      rd_data_o <= summary_word;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_summary;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_summary_o <= `PSS_RESET_SUMMARY;
    end else begin
      status_summary_o <= summary_word;
    end
  end

endmodule

`default_nettype wire
